/* File: hw/qcr_quad_read.sv */
/*
 Device side of the quad I/O read with continuous read mode.
 Assumes the host drives sck_i in SPI mode 0 or 3 and stops it outside
 frames, and that the memory port answers from the system clock domain.
*/
// Operation
// - EBh takes address four bits per clock.
// - E7h forces address bits 1:0 to zero.
// - EBh alignment follows the word aligned flag.
// - First frame: serial opcode, then quad address/data.
// - Continuous mode frames start directly with address.
// - Mode byte follows address, decides continuous mode.
// - Opcode is eight clocks, MSB first.
// - Address is six nibbles, MSB nibble first.
// - Dummy cycles follow address, mode byte included.
// - Pins turn to outputs after dummy cycles.
// - Each byte in two clocks, high nibble first.
// - Chip select high ends read, pins released.
// - Address wraps from top to zero seamlessly.
// - Dummy count comes from status bits 6:4.
// - Aligned flag is status bit 0; E7h ignores.
// - Settings 000..100 give 2..10 dummy cycles.
`default_nettype none

module qcr_quad_read
   import qcr_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Serial link
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_o,
   // Configuration and status
   input wire logic [7:0] status5_i,
   output logic continuous_read_mode_o,
   // Array read port
   output qcr_mem_req_type mem_o,
   input wire logic mem_ack_i,
   input wire logic [7:0] mem_rdata_i
);

   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      for (int i = PW - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
      end
      gray2bin = b;
   endfunction : gray2bin

   // Index of the last dummy clock, 2*(dc+1)-1, settings above the top clamped.
   function automatic logic [3:0] dummy_last(input logic [2:0] dc);
      dummy_last = {((dc > DC_MAX) ? DC_MAX : dc), 1'b1};
   endfunction : dummy_last

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   // A frame ends by chip select alone, since the serial clock stops with it.
   wire frame_rst_n = rst_n_i & ~cs_n_i;

   qcr_state_type state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [23:0] sh_r;
   logic [3:0] mode_hi_r;
   logic [7:0] byte_r;
   logic phase_r;
   logic crm_r;
   logic op_e7_r;
   logic req_tgl_r;
   logic [ADDR_W-1:0] start_addr_r;
   logic [3:0] cfg_s1_r, cfg_s2_r;
   logic [PW-1:0] wq1_r, wq2_r;
   logic [PW-1:0] rbin_r, rgray_r;
   // Write pointer kept in gray code, so only one bit moves as it crosses.
   logic [PW-1:0] wbin_r, wgray_r;
   logic [3:0] io_o_r, io_oe_r;
   qcr_entry_type fifo_mem [DEPTH];

   wire [2:0] dc_w = cfg_s2_r[3:1];
   wire waf_w = cfg_s2_r[0];
   wire [3:0] dum_last_w = dummy_last(dc_w);
   wire [7:0] op_w = {sh_r[6:0], io_i[0]};
   wire quad_w = (op_w == OP_QREAD) || (op_w == OP_QREAD_AL);
   wire [ADDR_W-1:0] addr_w = {sh_r[19:0], io_i};
   wire align_w = op_e7_r | waf_w;
   wire [7:0] mode_w = {mode_hi_r, io_i};
   wire addr_end_w = (state_r == ST_ADDR) && (cnt_r == ADDR_LAST);
   wire empty_w = (gray2bin(wq2_r) == rbin_r);
   qcr_entry_type head_w;
   assign head_w = fifo_mem[rbin_r[AW-1:0]];
   wire head_ok_w = !empty_w && (head_w.gen == req_tgl_r);
   wire stale_w = !empty_w && (head_w.gen != req_tgl_r);
   wire load_w = ((state_r == ST_DUMMY) && (cnt_r == dum_last_w)) ||
                 ((state_r == ST_DATA) && phase_r);
   wire pop_w = stale_w || (load_w && head_ok_w);
   wire [PW-1:0] rbin_nxt = rbin_r + PW'(pop_w);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 4'h1;
      case (state_r)
         ST_HEAD: begin
            state_nxt = crm_r ? ST_ADDR : ST_CMD;
         end
         ST_CMD: begin
            if (cnt_r == CMD_LAST) begin
               state_nxt = quad_w ? ST_ADDR : ST_IGNORE;
               cnt_nxt = 4'h0;
            end
         end
         ST_ADDR: begin
            if (addr_end_w) begin
               state_nxt = ST_DUMMY;
               cnt_nxt = 4'h0;
            end
         end
         ST_DUMMY: begin
            if (cnt_r == dum_last_w) begin
               state_nxt = ST_DATA;
            end
         end
         ST_DATA: begin
            cnt_nxt = cnt_r;
         end
         ST_IGNORE: begin
            cnt_nxt = cnt_r;
         end
         default: begin
            state_nxt = ST_IGNORE;
         end
      endcase
   end

   // Frame state, sampled on the rising edge.
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state_r <= ST_HEAD;
         cnt_r <= 4'h0;
         sh_r <= 24'h0;
         mode_hi_r <= 4'h0;
         byte_r <= 8'h0;
         phase_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= (state_r == ST_HEAD) ? 4'h1 : cnt_nxt;
         if (state_r == ST_CMD || (state_r == ST_HEAD && !crm_r)) begin
            sh_r <= {sh_r[22:0], io_i[0]};
         end else begin
            sh_r <= {sh_r[19:0], io_i};
         end
         if (state_r == ST_DUMMY && cnt_r == 4'h0) begin
            mode_hi_r <= io_i;
         end
         if (load_w) begin
            byte_r <= head_ok_w ? head_w.data : UNDERRUN_BYTE;
         end
         phase_r <= (state_r == ST_DATA) ? ~phase_r : 1'b0;
      end
   end

   // State kept across frames.
   always_ff @(posedge sck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crm_r <= 1'b0;
         op_e7_r <= 1'b0;
         req_tgl_r <= 1'b0;
         start_addr_r <= 24'h0;
         cfg_s1_r <= 4'h0;
         cfg_s2_r <= 4'h0;
         wq1_r <= '0;
         wq2_r <= '0;
         rbin_r <= '0;
         rgray_r <= '0;
      end else begin
         cfg_s1_r <= {status5_i[DC_MSB:DC_LSB], status5_i[WAF_BIT]};
         cfg_s2_r <= cfg_s1_r;
         wq1_r <= wgray_r;
         wq2_r <= wq1_r;
         rbin_r <= rbin_nxt;
         rgray_r <= bin2gray(rbin_nxt);
         if (!cs_n_i && state_r == ST_CMD && cnt_r == CMD_LAST && quad_w) begin
            op_e7_r <= (op_w == OP_QREAD_AL);
         end
         if (!cs_n_i && state_r == ST_DUMMY && cnt_r == MODE_LAST) begin
            crm_r <= (mode_w == MODE_CONT);
         end
         if (!cs_n_i && addr_end_w) begin
            req_tgl_r <= ~req_tgl_r;
            start_addr_r <= align_w ? {addr_w[ADDR_W-1:2], 2'b00} : addr_w;
         end
      end
   end

   // Pins change on the falling edge; chip select high releases them at once.
   always_ff @(negedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         io_o_r <= 4'h0;
         io_oe_r <= 4'h0;
      end else begin
         io_oe_r <= {4{state_r == ST_DATA}};
         io_o_r <= phase_r ? byte_r[3:0] : byte_r[7:4];
      end
   end

   assign io_o = io_o_r;
   assign io_oe_o = io_oe_r;
   assign continuous_read_mode_o = crm_r;

   // ----------------------------------------------------------------
   // System domain prefetch
   // ----------------------------------------------------------------
   // Entries carry the frame generation so stale prefetch is dropped by the
   // reader; the writer never has to reach across domains to flush.
   logic tq1_r, tq2_r, tq3_r;
   logic [PW-1:0] rq1_r, rq2_r;
   logic gen_r;
   logic active_r;
   qcr_mem_req_type mem_r;

   wire new_req_w = tq2_r ^ tq3_r;
   wire wr_en_w = mem_r.req && mem_ack_i && !new_req_w;
   wire [PW-1:0] wbin_nxt = wbin_r + PW'(wr_en_w);
   wire [PW-1:0] level_nxt = wbin_nxt - gray2bin(rq2_r);
   wire wr_ready_w = (level_nxt != PW'(DEPTH));
   wire [ARRAY_W-1:0] addr_inc_w = mem_r.addr + ARRAY_W'(1);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tq1_r <= 1'b0;
         tq2_r <= 1'b0;
         tq3_r <= 1'b0;
         rq1_r <= '0;
         rq2_r <= '0;
         wbin_r <= '0;
         wgray_r <= '0;
         gen_r <= 1'b0;
         active_r <= 1'b0;
         mem_r <= '0;
      end else if (clk_en_i) begin
         tq1_r <= req_tgl_r;
         tq2_r <= tq1_r;
         tq3_r <= tq2_r;
         rq1_r <= rgray_r;
         rq2_r <= rq1_r;
         wbin_r <= wbin_nxt;
         wgray_r <= bin2gray(wbin_nxt);
         if (new_req_w) begin
            gen_r <= tq2_r;
            active_r <= 1'b1;
            mem_r.addr <= start_addr_r[ARRAY_W-1:0];
         end else if (wr_en_w) begin
            mem_r.addr <= addr_inc_w;
         end
         mem_r.req <= active_r && !new_req_w && wr_ready_w;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clk_en_i && wr_en_w) begin
         fifo_mem[wbin_r[AW-1:0]] <= '{gen: gen_r, data: mem_rdata_i};
      end
   end

   assign mem_o = mem_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [3:0] dcnt_h;

   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         dcnt_h <= 4'h0;
      end else if (state_r == ST_DUMMY) begin
         dcnt_h <= dcnt_h + 4'h1;
      end
   end

   a_pins_released: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cs_n_i |-> (io_oe_o == 4'h0))
      else $error("pins driven while chip select is high");

   a_drive_in_data: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_DATA && $past(state_r) == ST_DATA) |-> (io_oe_o == 4'hF))
      else $error("pins not driven during data phase");

   a_quiet_before: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r != ST_DATA) |-> (io_oe_o == 4'h0))
      else $error("pins driven before dummy phase ended");

   a_opcode_len: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_HEAD && !crm_r) |=> (state_r == ST_CMD)[*7] ##1 (state_r != ST_CMD))
      else $error("opcode phase not eight clocks");

   a_addr_six: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_CMD && cnt_r == CMD_LAST && quad_w) |=>
         (state_r == ST_ADDR)[*6] ##1 (state_r == ST_DUMMY))
      else $error("address phase not six clocks");

   a_align_low: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_DUMMY && $past(state_r) == ST_ADDR && $past(align_w)) |->
         (start_addr_r[1:0] == 2'b00))
      else $error("aligned read kept low address bits");

   a_dummy_count: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_DATA && $past(state_r) == ST_DUMMY) |->
         (dcnt_h == dummy_last(dc_w) + 4'h1))
      else $error("dummy phase length wrong");

   a_mode_change: assert property (@(posedge sck_i) disable iff (!rst_n_i)
      $changed(crm_r) |-> ($past(state_r) == ST_DUMMY && $past(cnt_r) == MODE_LAST))
      else $error("continuous mode changed outside mode field");

   a_nibble_order: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_DATA && io_oe_o[0]) |->
         (io_o == (phase_r ? byte_r[3:0] : byte_r[7:4])))
      else $error("data nibble out of order");

   a_wrap_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk_en_i && wr_en_w && mem_r.addr == {ARRAY_W{1'b1}}) |=>
         (mem_o.addr == '0))
      else $error("array address did not wrap to zero");

   c_enter_crm: cover property (@(posedge sck_i) disable iff (!rst_n_i) $rose(crm_r));
   c_short_frame: cover property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_HEAD && crm_r) ##1 (state_r == ST_ADDR));
   c_data_bytes: cover property (@(posedge sck_i) disable iff (!frame_rst_n)
      (state_r == ST_DATA)[*4]);
   c_wrap: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_en_w && mem_r.addr == {ARRAY_W{1'b1}}));

endmodule : qcr_quad_read

`default_nettype wire

/* File: pkg/qcr_pkg.sv */
/*
 Shared constants and types for the quad I/O continuous read block.
 Assumes one flash array of 2**ARRAY_W bytes behind a simple request port.
*/
`default_nettype none

package qcr_pkg;

   // ----------------------------------------------------------------
   // Opcodes and mode field
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_QREAD = 8'hEB;
   localparam logic [7:0] OP_QREAD_AL = 8'hE7;
   // Continuation pattern of the mode byte.
   localparam logic [7:0] MODE_CONT = 8'hA0;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_LAST = 4'h7;
   localparam logic [3:0] ADDR_LAST = 4'h5;
   localparam logic [3:0] MODE_LAST = 4'h1;
   localparam int ADDR_W = 24;
   localparam int ARRAY_W = 22;

   // ----------------------------------------------------------------
   // Fifth status register fields
   // ----------------------------------------------------------------
   localparam int WAF_BIT = 0;
   localparam int DC_LSB = 4;
   localparam int DC_MSB = 6;
   localparam logic [2:0] DC_MAX = 3'h4;
   localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HEAD = 3'h0,
      ST_CMD = 3'h1,
      ST_ADDR = 3'h3,
      ST_DUMMY = 3'h2,
      ST_DATA = 3'h6,
      ST_IGNORE = 3'h7
   } qcr_state_type;

   typedef struct packed {
      logic gen;
      logic [7:0] data;
   } qcr_entry_type;

   typedef struct packed {
      logic req;
      logic [ARRAY_W-1:0] addr;
   } qcr_mem_req_type;

endpackage : qcr_pkg

`default_nettype wire

/* File: verif/qcr_mem_model.sv */
/*
 Array model for the quad read bench: answers at once or every other cycle.
 Assumes requests come from qcr_quad_read in the system clock domain.
*/
`default_nettype none

module qcr_mem_model
   import qcr_pkg::*;
(
   // Clock and control
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   // Array port
   input wire qcr_mem_req_type mem_i,
   output logic mem_ack_o,
   output logic [7:0] mem_rdata_o
);
   logic stall_r;
   logic [7:0] val;

   assign val = mem_i.addr[7:0] ^ mem_i.addr[15:8] ^ {2'h0, mem_i.addr[21:16]};
   assign mem_ack_o = mem_i.req & ~(slow_i & stall_r);
   // An unanswered read shows the inverse, so a late sample cannot pass by luck.
   assign mem_rdata_o = mem_ack_o ? val : ~val;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stall_r <= 1'b0;
      end else begin
         stall_r <= ~stall_r;
      end
   end
endmodule : qcr_mem_model

`default_nettype wire

/* File: verif/qcr_quad_read_tb.sv */
/*
 Self-checking bench for qcr_quad_read: the bench acts as the serial host.
 Assumes a 25 ns system clock and a 48 ns serial clock that runs only in frames.
*/
`default_nettype none

module qcr_quad_read_tb;
   import qcr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sck_i = 1'b0;
   logic cs_n_i = 1'b1;
   logic slow = 1'b0;
   logic pause = 1'b0;
   logic [3:0] host_io = 4'hF;
   logic [7:0] status5_i = 8'h20;
   logic [3:0] io_o;
   logic [3:0] io_oe_o;
   logic [3:0] io_w;
   logic crm;
   logic ack;
   logic [7:0] rdata;
   qcr_mem_req_type mem_w;
   int num_errors = 0;
   int num_checks = 0;

   // Each pin shows the device while it drives, the host otherwise.
   assign io_w = (io_oe_o & io_o) | (~io_oe_o & host_io);

   always #12.5 clk_sys_i = ~clk_sys_i;

   qcr_quad_read i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
      .sck_i(sck_i), .cs_n_i(cs_n_i), .io_i(io_w), .io_o(io_o), .io_oe_o(io_oe_o),
      .status5_i(status5_i), .continuous_read_mode_o(crm), .mem_o(mem_w),
      .mem_ack_i(ack), .mem_rdata_i(rdata));

   qcr_mem_model i_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
      .mem_i(mem_w), .mem_ack_o(ack), .mem_rdata_o(rdata));

   // ----------------------------------------------------------------
   // Host helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] mval(input logic [21:0] a);
      return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
   endfunction : mval

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic clk1(input logic [3:0] v);
      host_io = v;
      #24 sck_i = 1'b1;
      #24 sck_i = 1'b0;
   endtask : clk1

   task automatic frame(input logic opf, input logic [7:0] op, input logic [23:0] a,
         input logic [7:0] md, input logic [2:0] dc, input logic [21:0] base,
         input int nnib, input logic dchk, input logic go);
      int nd;
      logic [3:0] hi;
      nd = (dc > 3'h4) ? 10 : 2 * (dc + 1);
      cs_n_i = 1'b0;
      #24;
      if (opf) for (int i = 7; i >= 0; i--) clk1({3'h7, op[i]});
      for (int i = 5; i >= 0; i--) clk1(a[i*4 +: 4]);
      for (int i = 0; i < nd; i++) begin
         chk("oe_dummy", 32'h0, io_oe_o);
         clk1(i == 0 ? md[7:4] : i == 1 ? md[3:0] : 4'(i));
      end
      for (int k = 0; k < nnib; k++) begin
         host_io = ~host_io;
         #23;
         chk("oe_data", go ? 32'hF : 32'h0, io_oe_o);
         if (k[0] == 1'b0) begin
            hi = io_o;
         end else if (dchk) begin
            chk("data", mval(22'(base + 22'(k / 2))), {hi, io_o});
         end
         if ((k == 2 || k == 6) && pause) begin
            #3000;
            chk("req_full", 32'h0, mem_w.req);
         end
         #1 sck_i = 1'b1;
         #24 sck_i = 1'b0;
      end
      cs_n_i = 1'b1;
      #1 chk("oe_cs", 32'h0, io_oe_o);
      #47;
   endtask : frame

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_first;
      frame(1'b1, OP_QREAD, 24'hC23457, MODE_CONT, 3'h2, 22'h023457, 8, 1'b1, 1'b1);
      chk("crm_on", 32'h1, crm);
      $display("test first done");
   endtask : t_first

   task automatic t_wrap;
      @(negedge clk_sys_i) slow = 1'b1;
      pause = 1'b1;
      frame(1'b0, 8'h00, 24'h3FFFFE, MODE_CONT, 3'h2, 22'h3FFFFE, 10, 1'b1, 1'b1);
      pause = 1'b0;
      chk("crm_kept", 32'h1, crm);
      @(negedge clk_sys_i) slow = 1'b0;
      $display("test wrap done");
   endtask : t_wrap

   task automatic t_exit_align;
      frame(1'b0, 8'h00, 24'h000100, 8'hFF, 3'h2, 22'h000100, 4, 1'b1, 1'b1);
      chk("crm_off", 32'h0, crm);
      @(negedge clk_sys_i) status5_i = 8'h20;
      frame(1'b1, OP_QREAD_AL, 24'h000013, 8'hFF, 3'h2, 22'h000010, 4, 1'b1, 1'b1);
      @(negedge clk_sys_i) status5_i = 8'h21;
      frame(1'b1, OP_QREAD, 24'h000013, 8'hFF, 3'h2, 22'h000010, 4, 1'b1, 1'b1);
      frame(1'b1, OP_QREAD_AL, 24'h000017, 8'hFF, 3'h2, 22'h000014, 4, 1'b1, 1'b1);
      @(negedge clk_sys_i) status5_i = 8'h20;
      frame(1'b1, OP_QREAD, 24'h000013, 8'hFF, 3'h2, 22'h000013, 4, 1'b1, 1'b1);
      $display("test exit_align done");
   endtask : t_exit_align

   task automatic t_dummy;
      // Short dummy phases may underrun the prefetch, so only the turnaround is judged.
      for (int d = 0; d < 6; d++) begin
         @(negedge clk_sys_i) status5_i = {1'b0, 3'(d), 4'h0};
         frame(1'b1, OP_QREAD, 24'h000200, 8'hFF, 3'(d), 22'h0, 2, 1'b0, 1'b1);
      end
      @(negedge clk_sys_i) status5_i = 8'h20;
      $display("test dummy done");
   endtask : t_dummy

   task automatic t_abort;
      frame(1'b1, OP_QREAD, 24'h000300, 8'hFF, 3'h2, 22'h000300, 1, 1'b0, 1'b1);
      frame(1'b1, 8'h03, 24'h000300, 8'hFF, 3'h2, 22'h0, 4, 1'b0, 1'b0);
      frame(1'b1, OP_QREAD, 24'h000301, 8'hFF, 3'h2, 22'h000301, 4, 1'b1, 1'b1);
      $display("test abort done");
   endtask : t_abort

   initial begin
      #2000000;
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (5) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      t_first();
      t_wrap();
      t_exit_align();
      t_dummy();
      t_abort();
      wrap_up();
   end
endmodule : qcr_quad_read_tb

`default_nettype wire
